// ==== external_bus_interface.sv ====
// External bus interface: decodes requests onto eight chip-select regions and
// drives the external strobes. Assumes a synchronous parallel bus on ref_clk.
//
// Notes on behaviour
// R1 - 24-bit address, eight selects, 16M bytes each
// R2 - Regions by base and page size
// R3 - Small memories repeat within their page
// R4 - Unmapped address raises prefetch or data abort
// R5 - Overlap asserts all; lowest select rules
// R6 - Abort address captured, last abort kept
// R7 - Abort cause: undefined, misaligned, size, type
// R8 - Abort capture reads zero after reset
// R9 - Internal access: address held, strobes idle
// R10 - Selects 0-3 low, 4-7 high on A20-23
// R11 - Swap field picks five pin assignments
// R12 - Per-select 8 or 16-bit data width
// R13 - 16-bit select chooses byte write/select
// R14 - Byte write: two write strobes, one read
// R15 - Byte select: lane selects, common strobes
// R16 - Select 0 boot defaults, width from strap
// R17 - Select 0 base applies after remap
// R18 - Early read after write adds wait
// R19 - Wide access split into narrow parts
`timescale 1ns/1ps
`include "ebi_defs.svh"
module external_bus_interface
  import ebi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Request and answer
  input wire logic req_valid,
  input wire req_s req,
  output logic req_ready,
  output logic resp_done,
  output logic [31:0] resp_rdata,
  output logic prefetch_abort,
  output logic data_abort,
  output logic [31:0] abort_vector,
  // Configuration
  input wire cs_cfg_s [7:0] chip_select_config,
  input wire logic chip_select_zero_wr,
  input wire cs_cfg_s chip_select_zero_config,
  input wire logic remap_cmd,
  input wire logic [2:0] address_swap,
  input wire logic early_read,
  input wire logic boot_width_strap,
  // Abort and remap status
  output logic [31:0] abort_address_capture,
  output abort_cause_s abort_cause_status,
  output logic remapped,
  // External pins
  output logic [23:0] addr_pins,
  output logic [3:0] low_active_selects_n,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in,
  output logic read_strobe_n,
  output logic lower_byte_write_strobe_n,
  output logic upper_byte_write_strobe_n,
  output logic output_enable_strobe_n,
  output logic common_write_strobe_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n
);

  // Whole state of the block
  typedef struct packed {
    ebi_state_e st;
    logic strap_a; // Strap synchroniser first stage
    logic strap_b; // Strap synchroniser second stage
    logic strap_load; // Catch strap once after reset release
    logic remapped;
    cs_cfg_s cs0; // Select 0 configuration, boot defaults
    req_s rq; // Latched request
    logic [7:0] match; // All selects hit by the request
    cs_cfg_s cfg; // Configuration of the ruling select
    logic [1:0] part; // Current part of a split access
    logic [1:0] last_part;
    logic [3:0] wcnt; // Wait cycles left in this part
    logic [23:0] ext_addr; // Held after the access ends
    logic [31:0] rdata;
    logic last_wr; // Last external access was a write
    logic done;
    logic pabort;
    logic dabort;
    logic [31:0] vector;
    logic [31:0] abort_addr;
    abort_cause_s cause;
  } state_s;

  state_s s;
  state_s next_s;

  // Effective per-select configuration, select 0 taken from its own register
  cs_cfg_s eff [8];
  logic [7:0] hit;
  logic [2:0] ruler;
  logic misal;

  // Address decode: masked compare of bits 31..20 against every base
  always_comb begin
    for (int i = 0; i < `EBI_NUM_CS; i++) begin
      eff[i] = (i == 0) ? s.cs0 : chip_select_config[i];
    end
    if (!s.remapped) begin
      eff[0].base = `EBI_BOOT_BASE; // R17
    end
    for (int i = 0; i < `EBI_NUM_CS; i++) begin
      // Low address bits pass untouched, so a small memory repeats in its page
      hit[i] = ((req.addr[31:20] ^ eff[i].base) &
        (`EBI_PAGE_MASK_ALL << {eff[i].page, 1'b0})) == 12'h000; // R2 R3
    end
    // Lowest numbered hit rules the access
    ruler = 3'h0;
    for (int i = `EBI_NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        ruler = i[2:0]; // R5
      end
    end
    // Misaligned half-words and words
    case (req.size)
      `EBI_SIZE_HALF: misal = req.addr[0];
      `EBI_SIZE_WORD: misal = req.addr[1:0] != 2'h0;
      default: misal = 1'b0;
    endcase
  end

  // Next state
  always_comb begin
    cs_cfg_s c;
    logic w16;
    c = eff[ruler];
    w16 = 1'b0;
    next_s = s;
    next_s.done = 1'b0;
    next_s.pabort = 1'b0;
    next_s.dabort = 1'b0;
    // Strap passes two flops, then is caught once after reset
    next_s.strap_a = boot_width_strap;
    next_s.strap_b = s.strap_a;
    next_s.strap_load = 1'b0;
    if (s.strap_load) begin
      next_s.cs0.bus_width_select = s.strap_b; // R16
    end
    // Software may rewrite select 0 at any time; base waits for remap
    if (chip_select_zero_wr) begin
      next_s.cs0 = chip_select_zero_config; // R17
    end
    if (remap_cmd) begin
      next_s.remapped = 1'b1; // R17
    end
    case (s.st)
      st_idle: begin
        if (req_valid && req.internal) begin
          // Pins keep their last external level
          next_s.done = 1'b1; // R9
        end else if (req_valid && (hit == 8'h00 || misal)) begin
          next_s.done = 1'b1;
          next_s.abort_addr = req.addr; // R6
          next_s.cause.undefined = hit == 8'h00; // R7
          next_s.cause.misaligned = misal;
          next_s.cause.size = req.size;
          next_s.cause.kind = req.fetch ? `EBI_TYPE_FETCH :
            (req.write ? `EBI_TYPE_WRITE : `EBI_TYPE_READ);
          next_s.pabort = req.fetch; // R4
          next_s.dabort = !req.fetch;
          next_s.vector = req.fetch ? `EBI_PREFETCH_VECTOR : `EBI_DATA_VECTOR;
        end else if (req_valid) begin
          w16 = c.bus_width_select; // R12
          next_s.rq = req;
          next_s.match = hit; // R5
          next_s.cfg = c;
          next_s.part = 2'h0;
          next_s.rdata = 32'h0;
          // Parts per access: word 2 or 4, half 1 or 2, byte 1
          case (req.size)
            `EBI_SIZE_WORD: next_s.last_part = w16 ? 2'h1 : 2'h3; // R19
            `EBI_SIZE_HALF: next_s.last_part = w16 ? 2'h0 : 2'h1;
            default: next_s.last_part = 2'h0;
          endcase
          next_s.ext_addr = req.addr[23:0]; // R1
          next_s.wcnt = c.wait_state_enable ? c.wait_count : 4'h0;
          // Read after write in early protocol gets a spare cycle
          next_s.st = (early_read && s.last_wr && !req.write) ? st_early
            : st_strobe; // R18
        end
      end
      st_early: begin
        next_s.st = st_strobe; // R18
      end
      st_strobe: begin
        if (s.wcnt != 4'h0) begin
          next_s.wcnt = s.wcnt - 4'h1;
        end else begin
          // Read capture at the end of each part
          if (!s.rq.write) begin
            if (!s.cfg.bus_width_select) begin
              next_s.rdata[{s.part, 3'h0} +: 8] = data_in[7:0];
            end else if (s.rq.size == `EBI_SIZE_BYTE) begin
              next_s.rdata[7:0] = s.ext_addr[0] ? data_in[15:8] : data_in[7:0];
            end else begin
              next_s.rdata[{s.part[0], 4'h0} +: 16] = data_in;
            end
          end
          if (s.part != s.last_part) begin
            next_s.part = s.part + 2'h1; // R19
            next_s.ext_addr = s.ext_addr +
              (s.cfg.bus_width_select ? 24'h000002 : 24'h000001);
            next_s.wcnt = s.cfg.wait_state_enable ? s.cfg.wait_count : 4'h0;
          end else begin
            next_s.st = st_idle;
            next_s.done = 1'b1;
            next_s.last_wr = s.rq.write;
          end
        end
      end
      default: next_s.st = st_idle;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0; // R8
      s.st <= st_idle;
      s.strap_load <= 1'b1;
      // Strap keeps flowing while reset is held, else select 0 boots on a zero
      s.strap_a <= boot_width_strap; // R16
      s.strap_b <= s.strap_a;
      s.cs0.wait_count <= `EBI_CS0_BOOT_WAITS; // R16
    end else begin
      s <= next_s;
    end
  end

  // Pin and strobe decode
  logic strobe;
  logic lane_lo;
  logic lane_hi;
  logic bsel;
  logic [7:0] cs_on;
  always_comb begin
    strobe = s.st == st_strobe;
    cs_on = (s.st != st_idle) ? s.match : 8'h00; // R5
    // Byte accesses on a 16-bit select use one lane
    lane_lo = !s.cfg.bus_width_select || s.rq.size != `EBI_SIZE_BYTE ||
      !s.ext_addr[0];
    lane_hi = s.cfg.bus_width_select &&
      (s.rq.size != `EBI_SIZE_BYTE || s.ext_addr[0]);
    bsel = s.cfg.bus_width_select && s.cfg.byte_access_type; // R13
    // Top address lines give way to high selects from A23 down
    addr_pins = s.ext_addr;
    for (int k = 0; k < 4; k++) begin
      if (k < address_swap) begin
        addr_pins[23 - k] = cs_on[4 + k]; // R10 R11
      end
    end
    if (bsel) begin
      addr_pins[0] = !(strobe && lane_lo); // R15
    end
    low_active_selects_n = ~cs_on[3:0]; // R10
    // Byte write strobes, also used for 8-bit selects
    read_strobe_n = !(strobe && !s.rq.write && !bsel); // R14
    lower_byte_write_strobe_n = !(strobe && s.rq.write && !bsel && lane_lo);
    upper_byte_write_strobe_n = !(strobe && s.rq.write && !bsel && lane_hi);
    // Byte select strobes
    output_enable_strobe_n = !(strobe && !s.rq.write && bsel); // R15
    common_write_strobe_n = !(strobe && s.rq.write && bsel);
    lower_byte_select_n = !(strobe && bsel && lane_lo);
    upper_byte_select_n = !(strobe && bsel && lane_hi);
    // Write data bus, released outside writes
    data_oe = strobe && s.rq.write; // R9
    if (!s.cfg.bus_width_select) begin
      data_out = {8'h00, s.rq.wdata[{s.part, 3'h0} +: 8]};
    end else if (s.rq.size == `EBI_SIZE_BYTE) begin
      data_out = {s.rq.wdata[7:0], s.rq.wdata[7:0]};
    end else begin
      data_out = s.rq.wdata[{s.part[0], 4'h0} +: 16];
    end
  end

  // Answer outputs
  assign req_ready = s.st == st_idle;
  assign resp_done = s.done;
  assign resp_rdata = s.rdata;
  assign prefetch_abort = s.pabort;
  assign data_abort = s.dabort;
  assign abort_vector = s.vector;
  assign abort_address_capture = s.abort_addr;
  assign abort_cause_status = s.cause;
  assign remapped = s.remapped;

  // Checks
  sequence unmapped_req;
    req_valid && req_ready && !req.internal && hit == 8'h00;
  endsequence
  sequence internal_req;
    req_valid && req_ready && req.internal;
  endsequence

  a_idle_strobes: assert property (@(posedge ref_clk) disable iff (rst) // R9
    internal_req |=> $stable(addr_pins[19:0]) && low_active_selects_n == 4'hf
      && read_strobe_n && !data_oe)
    else $error("internal access touched the external bus");
  a_abort_capture: assert property (@(posedge ref_clk) disable iff (rst) // R6
    unmapped_req |=> abort_address_capture == $past(req.addr) && resp_done
      && abort_cause_status.undefined)
    else $error("abort address not captured");
  a_abort_kind: assert property (@(posedge ref_clk) disable iff (rst) // R4
    unmapped_req |=> (prefetch_abort ? abort_vector == `EBI_PREFETCH_VECTOR
      : (data_abort && abort_vector == `EBI_DATA_VECTOR)))
    else $error("wrong abort kind or vector");
  a_reset_zero: assert property (@(posedge ref_clk) // R8
    $fell(rst) |-> abort_address_capture == 32'h0 && abort_cause_status == '0)
    else $error("abort capture not zero after reset");
  a_overlap_rule: assert property (@(posedge ref_clk) disable iff (rst) // R5
    req_valid && req_ready && !req.internal && hit != 8'h00 && !misal
      |=> s.match == $past(hit) && s.cfg == $past(eff[ruler]))
    else $error("overlap select handling wrong");
  a_early_wait: assert property (@(posedge ref_clk) disable iff (rst) // R18
    req_valid && req_ready && !req.internal && hit != 8'h00 && !misal
      && early_read && s.last_wr && !req.write
      |=> s.st == st_early ##1 s.st == st_strobe)
    else $error("early read wait missing");
  a_split_word: assert property (@(posedge ref_clk) disable iff (rst) // R19
    req_valid && req_ready && !req.internal && hit != 8'h00 && !misal
      && req.size == `EBI_SIZE_WORD && !eff[ruler].bus_width_select
      |=> s.last_part == 2'h3)
    else $error("8-bit word not split in four");
  a_swap_default: assert property (@(posedge ref_clk) disable iff (rst) // R11
    address_swap == `EBI_SWAP_NONE |-> addr_pins[23:20] == s.ext_addr[23:20])
    else $error("top address lines swapped by default");
  a_boot_base: assert property (@(posedge ref_clk) disable iff (rst) // R17
    req_valid && req_ready && !req.internal && !remapped && !misal
      && req.addr[31:20] == `EBI_BOOT_BASE |=> !low_active_selects_n[0])
    else $error("select 0 base used before remap");
  a_cause_fields: assert property (@(posedge ref_clk) disable iff (rst) // R7
    unmapped_req |=> abort_cause_status.size == $past(req.size)
      && abort_cause_status.kind == ($past(req.fetch) ? `EBI_TYPE_FETCH
      : ($past(req.write) ? `EBI_TYPE_WRITE : `EBI_TYPE_READ)))
    else $error("abort cause fields wrong");
  a_write_strobes: assert property (@(posedge ref_clk) disable iff (rst) // R14
    strobe && s.rq.write && !bsel |-> common_write_strobe_n && output_enable_strobe_n
      && (!lower_byte_write_strobe_n || !upper_byte_write_strobe_n))
    else $error("byte write strobes wrong");
  a_select_lanes: assert property (@(posedge ref_clk) disable iff (rst) // R15
    strobe && bsel |-> read_strobe_n && lower_byte_write_strobe_n
      && upper_byte_write_strobe_n && (!lower_byte_select_n || !upper_byte_select_n))
    else $error("byte select strobes wrong");
  a_boot_config: assert property (@(posedge ref_clk) disable iff (rst) // R16
    s.strap_load && !chip_select_zero_wr |=> s.cs0.bus_width_select == $past(s.strap_b)
      && s.cs0.wait_count == `EBI_CS0_BOOT_WAITS && !s.cs0.wait_state_enable
      && !s.cs0.byte_access_type)
    else $error("select 0 boot configuration wrong");
endmodule

// ==== ebi_defs.svh ====
// Constants for the external bus interface: encodings, reset values, vectors.
// Assumes inclusion by the package and by the design module.
`ifndef EBI_DEFS_SVH
`define EBI_DEFS_SVH
`define EBI_ADDR_W 24
`define EBI_NUM_CS 8
`define EBI_SIZE_BYTE 2'h0
`define EBI_SIZE_HALF 2'h1
`define EBI_SIZE_WORD 2'h2
`define EBI_TYPE_READ 2'h0
`define EBI_TYPE_WRITE 2'h1
`define EBI_TYPE_FETCH 2'h2
`define EBI_PREFETCH_VECTOR 32'h0000000c
`define EBI_DATA_VECTOR 32'h00000010
`define EBI_CS0_BOOT_WAITS 4'h8
`define EBI_BOOT_BASE 12'h000
`define EBI_SWAP_NONE 3'h0
`define EBI_PAGE_MASK_ALL 12'hfff
`endif

// ==== ebi_pkg.sv ====
// Types shared by the external bus interface and its surroundings.
// Assumes ebi_defs.svh sits in the same folder.
`include "ebi_defs.svh"
package ebi_pkg;
  // Per chip-select configuration
  typedef struct packed {
    logic [11:0] base; // Address bits 31..20 of the region
    logic [1:0] page; // Page size 1M, 4M, 16M, 64M bytes
    logic wait_state_enable; // Programmed waits used
    logic [3:0] wait_count; // Number of wait cycles
    logic bus_width_select; // 1 = 16-bit, 0 = 8-bit
    logic byte_access_type; // 1 = byte select, 0 = byte write
  } cs_cfg_s;
  // Access request from core or DMA
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata; // Right aligned to size
    logic [1:0] size; // Byte, half-word, word
    logic write;
    logic fetch; // Instruction fetch
    logic internal; // Hits internal memory or peripherals
  } req_s;
  // Abort cause capture
  typedef struct packed {
    logic undefined;
    logic misaligned;
    logic [1:0] size;
    logic [1:0] kind; // Read, write or fetch
  } abort_cause_s;
  typedef enum logic [1:0] {st_idle, st_early, st_strobe} ebi_state_e;
endpackage

// ==== ext_mem_model.sv ====
// Behavioural external memory on the parallel bus: 512 bytes that wrap.
// Assumes active-low strobes and selects, sampled on ref_clk.
`timescale 1ns/1ps
module ext_mem_model (
  // Clock
  input wire logic ref_clk,
  // Bus from the interface
  input wire logic [23:0] addr_pins,
  input wire logic [3:0] low_active_selects_n,
  input wire logic [15:0] data_out,
  input wire logic rd_n,
  input wire logic wr_lo_n,
  input wire logic wr_hi_n,
  input wire logic we_n,
  input wire logic lb_n,
  input wire logic ub_n,
  // Part width, 1 = 16-bit
  input wire logic wide,
  // Read data back to the interface
  output logic [15:0] data_in
);
  logic [7:0] mem [0:511]; // Small part, repeats inside its page
  logic [15:0] last = 16'h5a5a; // Last value put on the bus
  logic [8:0] a; // Byte address, even on a 16-bit part
  logic sel; // Any select active
  assign sel = ~&low_active_selects_n;
  assign a = wide ? {addr_pins[8:1], 1'b0} : addr_pins[8:0];
  // Drive only while selected and read strobe low; else a changing pattern
  always_comb begin
    if (sel && !rd_n) begin
      data_in = wide ? {mem[a | 9'h1], mem[a]} : {~last[15:8], mem[a]};
    end else begin
      data_in = ~last;
    end
  end
  // Writes land at each edge with a strobe low; repeats are harmless
  always_ff @(posedge ref_clk) begin
    last <= data_in;
    if (sel && (!wr_lo_n || (!we_n && !lb_n))) begin
      mem[a] <= data_out[7:0];
    end
    if (sel && wide && (!wr_hi_n || (!we_n && !ub_n))) begin
      mem[a | 9'h1] <= data_out[15:8];
    end
  end
endmodule

// ==== tb_external_bus_interface.sv ====
// Self-checking bench for the external bus interface with a memory model.
// Assumes ebi_pkg, the design and ext_mem_model are compiled first.
`timescale 1ns/1ps
module tb_external_bus_interface;
  import ebi_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  req_s req = '0;
  cs_cfg_s [7:0] cfg;
  logic cs0_wr = 1'b0;
  cs_cfg_s cs0_cfg = '0;
  logic remap_cmd = 1'b0;
  logic [2:0] address_swap = 3'h0;
  logic early_read = 1'b0;
  logic wide = 1'b1; // Width of the part on the model
  logic strap = 1'b1; // Boot width pin, 1 = 16-bit
  logic [3:0] hi_seen; // Top four address pins seen high during the access
  logic req_ready, resp_done, prefetch_abort, data_abort, remapped, data_oe;
  logic [31:0] resp_rdata, abort_vector, abort_address_capture;
  abort_cause_s abort_cause_status;
  logic [23:0] addr_pins;
  logic [3:0] low_active_selects_n;
  logic [15:0] data_out, data_in;
  logic rd_n, wlo_n, whi_n, oe_n, we_n, ub_n, lb_n;
  int fails = 0;
  int check_count = 0;
  int lat; // Cycles from take to done
  logic [3:0] sel_seen; // Selects seen active during the access
  logic [1:0] ab; // Prefetch and data abort at done
  logic [31:0] rd, wd;
  external_bus_interface external_bus_interface_inst (.ref_clk(ref_clk), .rst(rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_done(resp_done),
    .resp_rdata(resp_rdata), .prefetch_abort(prefetch_abort), .data_abort(data_abort),
    .abort_vector(abort_vector), .chip_select_config(cfg), .chip_select_zero_wr(cs0_wr),
    .chip_select_zero_config(cs0_cfg), .remap_cmd(remap_cmd), .address_swap(address_swap),
    .early_read(early_read), .boot_width_strap(strap),
    .abort_address_capture(abort_address_capture), .abort_cause_status(abort_cause_status),
    .remapped(remapped), .addr_pins(addr_pins), .low_active_selects_n(low_active_selects_n),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .read_strobe_n(rd_n),
    .lower_byte_write_strobe_n(wlo_n), .upper_byte_write_strobe_n(whi_n),
    .output_enable_strobe_n(oe_n), .common_write_strobe_n(we_n),
    .upper_byte_select_n(ub_n), .lower_byte_select_n(lb_n));
  ext_mem_model ext_mem_model_inst (.ref_clk(ref_clk), .addr_pins(addr_pins),
    .low_active_selects_n(low_active_selects_n), .data_out(data_out), .rd_n(rd_n & oe_n),
    .wr_lo_n(wlo_n), .wr_hi_n(whi_n), .we_n(we_n), .lb_n(lb_n), .ub_n(ub_n), .wide(wide),
    .data_in(data_in));
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Expected cycles: take, optional early wait, then each part with its waits
  function automatic int exp_lat(input logic w16, input logic [1:0] sz, input int waits,
                                 input logic er);
    int parts;
    parts = w16 ? (sz == 2'h2 ? 2 : 1) : (sz == 2'h2 ? 4 : (sz == 2'h1 ? 2 : 1));
    return 1 + int'(er) + parts * (waits + 1);
  endfunction
  // One request, held until taken; done awaited under a bound
  task automatic access(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] kind,
                        input logic in);
    logic [23:0] held;
    held = addr_pins;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{addr: a, wdata: wd, size: sz, write: kind == 2'h1, fetch: kind == 2'h2,
             internal: in};
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // Done for an abort or internal access stands in the cycle right after the take
    lat = 1;
    sel_seen = '0;
    hi_seen = '0;
    #1;
    while (resp_done !== 1'b1 && lat < 60) begin
      sel_seen |= ~low_active_selects_n;
      hi_seen |= addr_pins[23:20];
      @(posedge ref_clk);
      #1;
      lat++;
    end
    ab = {prefetch_abort, data_abort};
    rd = resp_rdata;
    if (in) compare("held address", {8'h00, held}, {8'h00, addr_pins});
  endtask
  // Random write then read back at a (optionally wrapped) offset
  task automatic round_trip(input logic [31:0] a, input logic [1:0] sz, input logic w16,
                            input int waits, input logic [3:0] sel, input logic [31:0] ra);
    logic [31:0] d;
    d = $urandom & (sz == 2'h0 ? 32'hff : (sz == 2'h1 ? 32'hffff : 32'hffffffff));
    wd = d;
    wide = w16;
    access(a, sz, 2'h1, 1'b0);
    compare("write latency", exp_lat(w16, sz, waits, 1'b0), lat);
    compare("write selects", {28'h0, sel}, {28'h0, sel_seen});
    access(a + ra, sz, 2'h0, 1'b0);
    compare("read latency", exp_lat(w16, sz, waits, early_read), lat);
    compare("read data", d, rd);
  endtask
  // Unmapped or misaligned access and its capture
  task automatic abort_case(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] kind,
                            input logic mis);
    access(a, sz, kind, 1'b0);
    compare("abort latency", 1, lat);
    compare("abort pulses", kind == 2'h2 ? 2'b10 : 2'b01, ab);
    compare("abort vector", kind == 2'h2 ? 32'h0000000c : 32'h00000010, abort_vector);
    compare("abort address", a, abort_address_capture);
    compare("abort cause", {!mis, mis, sz, kind}, abort_cause_status);
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h7ac93e02));
    // Unused selects parked far away, all distinct
    for (int i = 0; i < 8; i++) begin
      cfg[i] = '{base: 12'h7f0 + 12'(i), page: 2'h0, wait_state_enable: 1'b0,
                 wait_count: 4'h0, bus_width_select: 1'b1, byte_access_type: 1'b0};
    end
    cfg[1].base = 12'h001;
    cfg[2] = '{12'h002, 2'h0, 1'b1, 4'h2, 1'b0, 1'b0};
    cfg[3] = '{12'h003, 2'h0, 1'b1, 4'h3, 1'b1, 1'b1};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    compare("cleared address", 0, abort_address_capture);
    compare("cleared cause", 0, abort_cause_status);
    compare("idle selects", 4'hf, low_active_selects_n);
    // Boot select 0 at base 0: 16-bit from strap, waits disabled
    round_trip(32'h00000040, 2'h2, 1'b1, 0, 4'h1, 32'h0);
    for (int s = 0; s < 3; s++) begin
      round_trip(32'h00100000 + ($urandom & 32'h1fc), 2'(s), 1'b1, 0, 4'h2, 0);
      round_trip(32'h00200000 + ($urandom & 32'h1fc), 2'(s), 1'b0, 2, 4'h4, 0);
      round_trip(32'h00300000 + ($urandom & 32'h1fc), 2'(s), 1'b1, 3, 4'h8, 0);
    end
    // Small part repeats inside its page
    round_trip(32'h00100010, 2'h1, 1'b1, 0, 4'h2, 32'h200);
    @(posedge ref_clk);
    early_read <= 1'b1;
    round_trip(32'h00100030, 2'h2, 1'b1, 0, 4'h2, 0);
    @(posedge ref_clk);
    early_read <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      abort_case(32'h80000000 + 32'(k * 16), 2'h2, 2'(k), 1'b0);
    end
    abort_case(32'h00100001, 2'h1, 2'h0, 1'b1);
    // Internal access leaves the bus alone
    access(32'h00300000, 2'h2, 2'h0, 1'b1);
    compare("internal latency", 1, lat);
    compare("internal selects", 0, {28'h0, sel_seen});
    // All four high selects swapped in; select 4 shows on the top pin
    @(posedge ref_clk);
    address_swap <= 3'h4;
    wd = 32'h0;
    access(32'h7f400000, 2'h0, 2'h1, 1'b0);
    compare("swap latency", 2, lat);
    compare("swap high selects", 4'h8, hi_seen);
    compare("swap low selects", 0, sel_seen);
    @(posedge ref_clk);
    address_swap <= 3'h0;
    // Overlap: select 3 moved onto select 1; select 1 timing must win
    @(posedge ref_clk);
    cfg[3].base <= 12'h001;
    round_trip(32'h00100020, 2'h2, 1'b1, 0, 4'ha, 0);
    // New select 0 base waits for remap
    @(posedge ref_clk);
    cs0_wr <= 1'b1;
    cs0_cfg <= '{12'h005, 2'h0, 1'b0, 4'h0, 1'b1, 1'b0};
    @(posedge ref_clk);
    cs0_wr <= 1'b0;
    round_trip(32'h00000080, 2'h2, 1'b1, 0, 4'h1, 0);
    @(posedge ref_clk);
    remap_cmd <= 1'b1;
    @(posedge ref_clk);
    remap_cmd <= 1'b0;
    @(posedge ref_clk);
    #1;
    compare("remapped", 1, remapped);
    round_trip(32'h00500000, 2'h2, 1'b1, 0, 4'h1, 0);
    abort_case(32'h00000000, 2'h2, 2'h0, 1'b0);
    // Second reset with the strap low: select 0 boots 8-bit at base 0
    @(posedge ref_clk);
    strap <= 1'b0;
    rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    compare("reset address", 0, abort_address_capture);
    compare("reset cause", 0, abort_cause_status);
    compare("reset remap", 0, remapped);
    round_trip(32'h00000044, 2'h2, 1'b0, 0, 4'h1, 0);
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
endmodule
